// File: design/tape_status_pkg.sv
package tape_status_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 3;

    // Byte offsets from the controller base address
    localparam logic [ADDR_W-1:0] CMD_PTR_OFFSET = 3'h0;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET  = 3'h2;

    // Status word field positions
    localparam int SC_BIT  = 15;
    localparam int UPE_BIT = 14;
    localparam int SPE_BIT = 13;
    localparam int RMR_BIT = 12;
    localparam int NXM_BIT = 11;
    localparam int NBA_BIT = 10;
    localparam int RDY_BIT = 7;
    localparam int OFL_BIT = 6;
    localparam int FC_LSB  = 4;
    localparam int TC_LSB  = 1;

    localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0400;
    localparam logic [8:0]        PANEL_CAPSTAN = 9'h0df;
    localparam logic [8:0]        PANEL_NONE    = 9'h000;

    typedef enum logic [2:0] {
        TC_NORMAL    = 3'h0,
        TC_ATTENTION = 3'h1,
        TC_ALERT     = 3'h2,
        TC_REJECT    = 3'h3,
        TC_RECOV_MOV = 3'h4,
        TC_RECOV_NOM = 3'h5,
        TC_POS_LOST  = 3'h6,
        TC_FATAL     = 3'h7
    } term_class_t;

    typedef enum logic [1:0] {
        FC_DIAG  = 2'h0,
        FC_IOSEQ = 2'h1,
        FC_CTRL  = 2'h2,
        FC_POWER = 2'h3
    } fatal_class_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;

    // End-of-command status posted by the transport
    typedef struct packed {
        logic         valid;
        logic         special;
        term_class_t  term;
        fatal_class_t fatal;
        logic         offline;
        logic         msg_written;
    } xport_report_t;

    // Asynchronous-to-command transport controls and levels
    typedef struct packed {
        logic sc_set;
        logic sc_clr;
        logic ready_set;
        logic ready_clr;
        logic set_char_ok;
        logic drive_init;
        logic online;
        logic at_bot;
    } xport_event_t;

    // Controller-detected error pulses
    typedef struct packed {
        logic host_bus_parity_err;
        logic serial_link_parity_err;
        logic missing_memory_err;
        logic diag_fail;
        logic ucode_parity_err;
        logic silo_parity_err;
        logic ioseq_parity_err;
    } ctrl_err_t;

endpackage

// File: design/load_sequencer.sv
`timescale 1ns/1ps
module load_sequencer (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic init_i,
    input  wire logic online_i,
    input  wire logic at_bot_i,
    output logic      busy_o,
    output logic      xport_reset_o,
    output logic      rewind_o,
    output logic      done_o
);
    typedef enum logic [2:0] {
        LD_IDLE   = 3'b001,
        LD_RESET  = 3'b010,
        LD_REWIND = 3'b100
    } load_state_t;

    load_state_t state_reg;
    load_state_t state_next;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            LD_IDLE:   state_next = LD_IDLE;
            LD_RESET:  state_next = online_i ? LD_REWIND : LD_IDLE;
            LD_REWIND: state_next = at_bot_i ? LD_IDLE : LD_REWIND;
            default:   state_next = LD_IDLE;
        endcase
        if (init_i) begin
            state_next = LD_RESET;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg     <= LD_RESET;
            busy_o        <= 1'b1;
            xport_reset_o <= 1'b0;
            rewind_o      <= 1'b0;
            done_o        <= 1'b0;
        end else begin
            state_reg     <= state_next;
            busy_o        <= (state_next != LD_IDLE);
            xport_reset_o <= (state_next == LD_RESET);
            rewind_o      <= (state_next == LD_REWIND);
            done_o        <= (state_reg != LD_IDLE) && !init_i &&
                             (state_next == LD_IDLE);
        end
    end
endmodule

// File: design/fatal_latch.sv
`timescale 1ns/1ps
module fatal_latch
    import tape_status_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         reset_n_i,
    input  wire logic         subsys_init_i,
    input  wire logic         drive_init_i,
    input  wire logic         power_fail_i,
    input  wire logic         diag_i,
    input  wire logic         ctrl_i,
    input  wire logic         ioseq_i,
    output logic              active_o,
    output fatal_class_t      class_o
);
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            active_o <= 1'b0;
            class_o  <= FC_DIAG;
        end else if (power_fail_i) begin
            active_o <= 1'b1;
            class_o  <= FC_POWER;
        end else if (diag_i) begin
            active_o <= 1'b1;
            class_o  <= FC_DIAG;
        end else if (ctrl_i) begin
            active_o <= 1'b1;
            class_o  <= FC_CTRL;
        end else if (ioseq_i) begin
            active_o <= 1'b1;
            class_o  <= FC_IOSEQ;
        end else if (subsys_init_i) begin
            active_o <= 1'b0;
        end else if (drive_init_i && class_o != FC_POWER) begin
            active_o <= 1'b0;
        end
    end
endmodule

// File: design/tape_subsystem_status_register.sv
`timescale 1ns/1ps
module tape_subsystem_status_register
    import tape_status_pkg::*;
(
    input  wire logic                       CLK_I,
    input  wire logic                       RESET_N_I,
    input  tape_status_pkg::bus_req_t       BUS_REQ_I,
    input  wire logic                       SUBSYS_PWRUP_I,
    input  wire logic                       POWER_FAIL_I,
    input  tape_status_pkg::xport_report_t  XPORT_REPORT_I,
    input  tape_status_pkg::xport_event_t   XPORT_EVENT_I,
    input  tape_status_pkg::ctrl_err_t      CTRL_ERR_I,
    output logic [15:0]                     RDATA_O,
    output logic [15:0]                     CMD_PTR_O,
    output logic                            CMD_START_O,
    output logic                            CMD_REJECT_O,
    output logic                            XPORT_RESET_O,
    output logic                            REWIND_REQ_O,
    output logic                            LOAD_BUSY_O,
    output logic [8:0]                      PANEL_CODE_O
);
    import tape_status_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic         status_wr;
    logic         cmd_wr;
    logic         subsys_init;
    logic         load_busy;
    logic         load_done;
    logic         xport_reset;
    logic         rewind;
    logic         fatal_active;
    fatal_class_t fatal_class;
    logic         fatal_ctrl_evt;
    logic         report_ok;
    logic         cmd_refused;
    logic         cmd_blocked;
    logic         cmd_taken;

    assign status_wr   = BUS_REQ_I.wr && (BUS_REQ_I.addr == STATUS_OFFSET);
    assign cmd_wr      = BUS_REQ_I.wr && (BUS_REQ_I.addr == CMD_PTR_OFFSET);
    assign subsys_init = status_wr || SUBSYS_PWRUP_I;

    ////////////////////////////////////////////////////////////////////////
    // Status bits

    logic         sc_reg;
    logic         upe_reg;
    logic         spe_reg;
    logic         rmr_reg;
    logic         nxm_reg;
    logic         nba_reg;
    logic         ready_reg;
    logic         offline_reg;
    logic [1:0]   fc_reg;
    logic [2:0]   tc_reg;
    logic [15:0]  status_word;

    ////////////////////////////////////////////////////////////////////////
    // Load sequence after initialize

    load_sequencer u_load (
        .clk_i         (CLK_I),
        .reset_n_i     (RESET_N_I),
        .init_i        (subsys_init),
        .online_i      (XPORT_EVENT_I.online),
        .at_bot_i      (XPORT_EVENT_I.at_bot),
        .busy_o        (load_busy),
        .xport_reset_o (xport_reset),
        .rewind_o      (rewind),
        .done_o        (load_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Fatal class latch

    assign fatal_ctrl_evt = CTRL_ERR_I.ucode_parity_err ||
                            CTRL_ERR_I.silo_parity_err ||
                            CTRL_ERR_I.serial_link_parity_err;

    fatal_latch u_fatal (
        .clk_i         (CLK_I),
        .reset_n_i     (RESET_N_I),
        .subsys_init_i (subsys_init),
        .drive_init_i  (XPORT_EVENT_I.drive_init),
        .power_fail_i  (POWER_FAIL_I),
        .diag_i        (CTRL_ERR_I.diag_fail),
        .ctrl_i        (fatal_ctrl_evt),
        .ioseq_i       (CTRL_ERR_I.ioseq_parity_err),
        .active_o      (fatal_active),
        .class_o       (fatal_class)
    );

    ////////////////////////////////////////////////////////////////////////
    // Command pointer acceptance

    // Transport status is taken only once the load sequence has ended
    assign report_ok   = XPORT_REPORT_I.valid && !load_busy;
    assign cmd_refused = cmd_wr && !ready_reg;
    assign cmd_blocked = cmd_wr && ready_reg && fatal_active &&
                         (fatal_class == FC_DIAG);
    assign cmd_taken   = cmd_wr && ready_reg && !cmd_blocked;

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            CMD_PTR_O    <= 16'h0000;
            CMD_START_O  <= 1'b0;
            CMD_REJECT_O <= 1'b0;
        end else begin
            CMD_START_O  <= cmd_taken && !subsys_init;
            CMD_REJECT_O <= cmd_blocked && !subsys_init;
            if (cmd_taken) begin
                CMD_PTR_O <= BUS_REQ_I.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Controller-owned error bits, cleared only by initialize

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            upe_reg <= 1'b0;
            spe_reg <= 1'b0;
            nxm_reg <= 1'b0;
            rmr_reg <= 1'b0;
        end else if (subsys_init) begin
            upe_reg <= 1'b0;
            spe_reg <= 1'b0;
            nxm_reg <= 1'b0;
            rmr_reg <= 1'b0;
        end else begin
            if (CTRL_ERR_I.host_bus_parity_err) begin
                upe_reg <= 1'b1;
            end
            if (CTRL_ERR_I.serial_link_parity_err) begin
                spe_reg <= 1'b1;
            end
            if (CTRL_ERR_I.missing_memory_err) begin
                nxm_reg <= 1'b1;
            end
            if (cmd_refused) begin
                rmr_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ready flag

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ready_reg <= 1'b0;
        end else if (subsys_init) begin
            ready_reg <= 1'b0;
        end else if (XPORT_EVENT_I.ready_set || load_done) begin
            ready_reg <= 1'b1;
        end else if (XPORT_EVENT_I.ready_clr || cmd_taken) begin
            ready_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Special condition

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sc_reg <= 1'b0;
        end else if (XPORT_EVENT_I.sc_set || cmd_refused ||
                     CTRL_ERR_I.host_bus_parity_err ||
                     CTRL_ERR_I.missing_memory_err) begin
            sc_reg <= 1'b1;
        end else if (fatal_active) begin
            sc_reg <= 1'b1;
        end else if (report_ok) begin
            sc_reg <= XPORT_REPORT_I.special;
        end else if (XPORT_EVENT_I.sc_clr) begin
            sc_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Class codes; refused modification leaves them untouched

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            tc_reg <= TC_NORMAL;
            fc_reg <= FC_DIAG;
        end else if (fatal_active) begin
            tc_reg <= TC_FATAL;
            fc_reg <= fatal_class;
        end else if (report_ok) begin
            tc_reg <= XPORT_REPORT_I.term;
            fc_reg <= XPORT_REPORT_I.fatal;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transport-owned bits

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            offline_reg <= 1'b0;
        end else if (report_ok) begin
            offline_reg <= XPORT_REPORT_I.offline;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            nba_reg <= STATUS_RESET[NBA_BIT];
        end else if (subsys_init || fatal_ctrl_evt ||
                     CTRL_ERR_I.diag_fail || POWER_FAIL_I ||
                     CTRL_ERR_I.ioseq_parity_err) begin
            nba_reg <= 1'b1;
        end else if (report_ok && XPORT_REPORT_I.term == TC_FATAL) begin
            nba_reg <= !XPORT_REPORT_I.msg_written;
        end else if (XPORT_EVENT_I.set_char_ok) begin
            nba_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and side outputs

    always_comb begin
        status_word                   = 16'h0000;
        status_word[SC_BIT]           = sc_reg;
        status_word[UPE_BIT]          = upe_reg;
        status_word[SPE_BIT]          = spe_reg;
        status_word[RMR_BIT]          = rmr_reg;
        status_word[NXM_BIT]          = nxm_reg;
        status_word[NBA_BIT]          = nba_reg;
        status_word[RDY_BIT]          = ready_reg;
        status_word[OFL_BIT]          = offline_reg;
        status_word[FC_LSB +: 2]      = fc_reg;
        status_word[TC_LSB +: 3]      = tc_reg;
        status_word[0]                = 1'b0;
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            RDATA_O <= 16'h0000;
        end else if (BUS_REQ_I.rd && BUS_REQ_I.addr == STATUS_OFFSET) begin
            RDATA_O <= status_word;
        end else if (BUS_REQ_I.rd) begin
            RDATA_O <= 16'h0000;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            XPORT_RESET_O <= 1'b0;
            REWIND_REQ_O  <= 1'b0;
            LOAD_BUSY_O   <= 1'b1;
            PANEL_CODE_O  <= PANEL_NONE;
        end else begin
            XPORT_RESET_O <= xport_reset;
            REWIND_REQ_O  <= rewind;
            LOAD_BUSY_O   <= load_busy;
            PANEL_CODE_O  <= (fatal_active && fatal_class == FC_DIAG) ?
                             PANEL_CAPSTAN : PANEL_NONE;
        end
    end

endmodule

// File: dv/tape_subsystem_status_register_assertions.sv
`timescale 1ns/1ps
module tape_status_assertions
    import tape_status_pkg::*;
(
    input  wire logic                     CLK_I,
    input  wire logic                     RESET_N_I,
    input  tape_status_pkg::bus_req_t     BUS_REQ_I,
    input  wire logic                     POWER_FAIL_I,
    input  tape_status_pkg::xport_event_t XPORT_EVENT_I,
    input  tape_status_pkg::ctrl_err_t    CTRL_ERR_I,
    input  wire logic [15:0]              RDATA_O,
    input  wire logic [15:0]              CMD_PTR_O,
    input  wire logic                     CMD_START_O,
    input  wire logic                     CMD_REJECT_O,
    input  wire logic                     XPORT_RESET_O,
    input  wire logic                     REWIND_REQ_O,
    input  wire logic                     LOAD_BUSY_O,
    input  wire logic [8:0]               PANEL_CODE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    ////////////////////////////////////////////////////////////////////////
    sequence s_status_wr;
        BUS_REQ_I.wr && BUS_REQ_I.addr == STATUS_OFFSET;
    endsequence
    sequence s_status_rd;
        BUS_REQ_I.rd && BUS_REQ_I.addr == STATUS_OFFSET;
    endsequence
    sequence s_ptr_wr;
        BUS_REQ_I.wr && BUS_REQ_I.addr == CMD_PTR_OFFSET;
    endsequence
    sequence s_rewinding;
        XPORT_RESET_O && XPORT_EVENT_I.online && !XPORT_EVENT_I.at_bot;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_status_wr_init: assert property (s_status_wr |-> ##2
        XPORT_RESET_O && LOAD_BUSY_O)
        else $error("status write did not start init");
    a_online_rewind: assert property (s_rewinding |=> REWIND_REQ_O)
        else $error("no rewind after init");
    a_load_release: assert property (REWIND_REQ_O && XPORT_EVENT_I.at_bot
        |-> ##2 !LOAD_BUSY_O)
        else $error("load busy held at bot");
    a_ptr_capture: assert property (CMD_START_O |-> CMD_PTR_O == $past(BUS_REQ_I.wdata))
        else $error("pointer not captured");
    a_start_single: assert property (CMD_START_O |=> !CMD_START_O)
        else $error("start longer than one cycle");
    a_unused_zero: assert property (s_status_rd |=> RDATA_O[0] == 1'b0 && RDATA_O[9:8] == 2'b00)
        else $error("unused status bits set");
    a_refused_sc: assert property (s_status_rd |=> !RDATA_O[RMR_BIT] || RDATA_O[SC_BIT])
        else $error("refused without special condition");
    a_diag_panel: assert property (CTRL_ERR_I.diag_fail && !POWER_FAIL_I |-> ##[1:2] PANEL_CODE_O == PANEL_CAPSTAN)
        else $error("panel code missing");
    a_reject_cause: assert property (CMD_REJECT_O |-> PANEL_CODE_O == PANEL_CAPSTAN)
        else $error("reject without fatal");
    a_no_start_fatal: assert property (PANEL_CODE_O == PANEL_CAPSTAN ##0 s_ptr_wr |=> !CMD_START_O)
        else $error("start while fatal latched");
endmodule
bind tape_subsystem_status_register tape_status_assertions u_chk (
    .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .BUS_REQ_I(BUS_REQ_I),
    .POWER_FAIL_I(POWER_FAIL_I), .XPORT_EVENT_I(XPORT_EVENT_I),
    .CTRL_ERR_I(CTRL_ERR_I), .RDATA_O(RDATA_O), .CMD_PTR_O(CMD_PTR_O),
    .CMD_START_O(CMD_START_O), .CMD_REJECT_O(CMD_REJECT_O),
    .XPORT_RESET_O(XPORT_RESET_O), .REWIND_REQ_O(REWIND_REQ_O),
    .LOAD_BUSY_O(LOAD_BUSY_O), .PANEL_CODE_O(PANEL_CODE_O));

// File: dv/host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model
    import tape_status_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic [15:0]          rdata_i,
    output tape_status_pkg::bus_req_t req_o
);
    initial req_o = '0;
    ////////////////////////////////////////////////////////////////////////
    // Released bus carries inverted address and data
    task automatic bus_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_i);
        #1 req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        #1 req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // Status read is a snapshot only
    task automatic bus_rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk_i);
        #1 req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h5a5a};
        @(posedge clk_i);
        #1 req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'ha5a5};
        d = rdata_i;
    endtask
endmodule

// File: dv/test_tape_subsystem_status_register.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_tape_subsystem_status_register;
    import tape_status_pkg::*;
    logic          clk = 1'b0;
    logic          rst_n, pwrup, pfail, online, at_bot, start, rej, xrst, rew;
    logic          busy;
    logic [15:0]   rdata, ptr, v, vb, d;
    logic [8:0]    panel;
    bus_req_t      req;
    xport_report_t r, q;
    xport_event_t  evp, e;
    ctrl_err_t     err, c;
    int            bad_count, checked, cyc, cnt, dly, n_start, n_rej, n_xrst;
    int            seed, x0;
    always #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    tape_subsystem_status_register dut (
        .CLK_I(clk), .RESET_N_I(rst_n), .BUS_REQ_I(req),
        .SUBSYS_PWRUP_I(pwrup), .POWER_FAIL_I(pfail), .XPORT_REPORT_I(r),
        .XPORT_EVENT_I({evp[7:2], online, at_bot}), .CTRL_ERR_I(err),
        .RDATA_O(rdata), .CMD_PTR_O(ptr), .CMD_START_O(start),
        .CMD_REJECT_O(rej), .XPORT_RESET_O(xrst), .REWIND_REQ_O(rew),
        .LOAD_BUSY_O(busy), .PANEL_CODE_O(panel));
    host_bus_model host (.clk_i(clk), .rdata_i(rdata), .req_o(req));
    ////////////////////////////////////////////////////////////////////////
    // Transport reaches the start of tape after a varying delay
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
        n_start <= n_start + (start === 1'b1);
        n_rej <= n_rej + (rej === 1'b1);
        n_xrst <= n_xrst + (xrst === 1'b1);
        cnt <= rew ? cnt + 1 : 0;
        if (xrst === 1'b1) begin
            at_bot <= 1'b0;
            dly <= 4 + $urandom % 5;
        end else if (rew === 1'b1 && cnt >= dly)
            at_bot <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] st(logic sc, logic need_buffer_address, logic rdy,
                                       logic transport_offline, logic [1:0] fc,
                                       logic [2:0] tc);
        st = {sc, 4'h0, need_buffer_address, 2'b00, rdy, transport_offline, fc, tc, 1'b0};
    endfunction
    task automatic drive(xport_report_t rr, xport_event_t ee, ctrl_err_t cc,
                         logic p);
        @(posedge clk);
        #1 {r, evp, err, pfail} = {rr, ee, cc, p};
        @(posedge clk);
        #1 {r, evp, err, pfail} = '0;
    endtask
    task automatic wait_load();
        repeat (3) @(posedge clk);
        #1;
        for (int n = 0; n < 100 && busy !== 1'b0; n++)
            @(posedge clk) #1;
        `CHK("load done", 1'b0, busy)
    endtask
    task automatic give_verdict();
        if (bad_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = $urandom(32'h3d526d72);
        {rst_n, pwrup, pfail, at_bot, r, evp, err} = '0;
        {cyc, cnt, n_start, n_rej, n_xrst, bad_count, checked} = '0;
        online = 1'b1;
        dly = 4;
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        wait_load();
        host.bus_rd(STATUS_OFFSET, v);
        `CHK("reset status", st(0, 1, 1, 0, 0, 0), v)
        for (int t = 0; t < 8; t++) begin
            q = '0;
            q.valid = 1'b1;
            q.special = (t != 0);
            q.term = term_class_t'(t);
            q.fatal = fatal_class_t'($urandom % 4);
            {q.offline, q.msg_written} = 2'($urandom);
            vb = st(t != 0, (t == 7) ? !q.msg_written : 1'b1, 1, q.offline,
                    q.fatal, 3'(t)) & ((t == 7) ? 16'hfffe : 16'hffce);
            drive(q, '0, '0, 1'b0);
            host.bus_rd(STATUS_OFFSET, v);
            `CHK("report", vb, v & ((t == 7) ? 16'hfffe : 16'hffce))
        end
        e = '0;
        e.set_char_ok = 1'b1;
        drive('0, e, '0, 1'b0);
        host.bus_rd(STATUS_OFFSET, v);
        `CHK("buffer known", 1'b0, v[NBA_BIT])
        for (int k = 0; k < 4; k++) begin
            e = '0;
            e[(k < 2) ? 7 - k : 2 + k] = 1'b1;
            drive('0, e, '0, 1'b0);
            host.bus_rd(STATUS_OFFSET, vb);
            `CHK("xport special", k == 0, vb[SC_BIT])
            `CHK("xport ready", k != 2, vb[RDY_BIT])
        end
        c = '0;
        {c.host_bus_parity_err, c.missing_memory_err} = 2'b11;
        drive('0, '0, c, 1'b0);
        d = 16'($urandom);
        host.bus_wr(CMD_PTR_OFFSET, d);
        `CHK("pointer", d, ptr)
        host.bus_wr(CMD_PTR_OFFSET, ~d);
        host.bus_rd(STATUS_OFFSET, v);
        `CHK("one start", 1, n_start)
        `CHK("refused", 4'hf, {v[15:14], v[12:11]})
        `CHK("codes kept", vb[5:1], v[5:1])
        x0 = n_xrst;
        host.bus_wr(STATUS_OFFSET, 16'($urandom));
        q = '0;
        {q.valid, q.special, q.term, q.offline} = {2'b11, TC_ALERT, !v[6]};
        drive(q, '0, '0, 1'b0);
        wait_load();
        host.bus_rd(STATUS_OFFSET, vb);
        `CHK("init pulse", x0 + 1, n_xrst)
        `CHK("init clears", 16'h0480, vb & 16'h7c80)
        `CHK("busy report", v[6:1], vb[6:1])
        host.bus_rd(3'h4, v);
        `CHK("unmapped", 16'h0000, v)
        for (int f = 0; f < 4; f++) begin
            c = '0;
            {c.diag_fail, c.ioseq_parity_err, c.ucode_parity_err} =
                3'b100 >> f;
            drive('0, '0, c, f == 3);
            host.bus_rd(STATUS_OFFSET, v);
            `CHK("fatal class", {f[1:0], 3'h7}, v[5:1])
            `CHK("no message", 1'b1, v[NBA_BIT])
            `CHK("panel", (f == 0) ? PANEL_CAPSTAN : PANEL_NONE, panel)
            if (f == 0) begin
                host.bus_wr(CMD_PTR_OFFSET, 16'h0f0f);
                @(posedge clk) #1;
                `CHK("reject", 1, n_rej)
                `CHK("no start", 1, n_start)
            end
            e = '0;
            e.drive_init = 1'b1;
            drive('0, e, '0, 1'b0);
            if (f == 3) begin
                host.bus_rd(STATUS_OFFSET, v);
                `CHK("power held", 5'h1f, v[5:1])
                host.bus_wr(STATUS_OFFSET, 16'h0000);
                wait_load();
            end
            q = '0;
            {q.valid, q.term} = {1'b1, TC_NORMAL};
            drive(q, '0, '0, 1'b0);
            host.bus_rd(STATUS_OFFSET, v);
            `CHK("fatal cleared", 3'h0, v[3:1])
            `CHK("panel off", PANEL_NONE, panel)
        end
        x0 = n_xrst;
        @(posedge clk);
        #1 pwrup = 1'b1;
        @(posedge clk);
        #1 pwrup = 1'b0;
        wait_load();
        host.bus_rd(STATUS_OFFSET, v);
        `CHK("power up init", x0 + 1, n_xrst)
        `CHK("power up status", 16'h0480, v & 16'h7c80)
        give_verdict();
    end
endmodule
